/* File: rtl/sei_pkg.sv */
// Function
// - Opcode byte first; set-latch 0000X110, clear-latch 0000X100, read-status 0000X101.
// - Status write 0000X001 plus one byte changes only the two protect bits.
// - Array read/write opcodes: upper nibble zero, bit3 ninth address, low bits 011/010.
// - Unknown opcode deselects the device until chip select falls again.
// - Set-latch must precede every write; latch sets only after chip select rises.
// - Latch clears at power-up, clear-latch, write completion, or write-protect low.
// - Clear-latch opcode waits for chip select rise, then clears the latch.
// - Read-status shifts the status byte out; accepted anytime, even while busy.
// - During a write cycle protect bits read frozen; busy and latch read live.
// - Busy bit reads one while a write cycle runs, else zero.
// - Protect bits select a write-locked region; unchangeable under hardware protection.
// - Status write needs chip select to rise right after the eighth data bit.
// - Accepted status write starts a fixed timed cycle; busy clears at its end.
// - Status write refused: latch clear, busy, bad chip select timing, write-protect low.
// - Array read loads the address from opcode bit and address byte, sends data.
// - Read continues while selected, address increments and wraps to zero.
// - Chip select rise ends a read anywhere; output stops driving at once.
// - Array read is refused while a write cycle runs.
// - Nine address bits are used; any higher bits are ignored.
// - Array write: opcode, address, data bytes up to the end of the page.
// - Bytes past page end wrap to the page start and overwrite.
// - Chip select must rise on a byte boundary; then a timed write cycle runs.
// - Array write refused: latch clear, busy, off boundary, write-protect low, locked page.
// - Data moves MSB first; input sampled on rising, output changes on falling clock.
// - Power-up clears busy and latch, keeps the protect bits.
package sei_pkg;
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 512;
  localparam logic [3:0] OP_UPPER = 4'h0;
  localparam logic [2:0] OP_SET_LATCH = 3'h6;
  localparam logic [2:0] OP_CLR_LATCH = 3'h4;
  localparam logic [2:0] OP_RD_STATUS = 3'h5;
  localparam logic [2:0] OP_WR_STATUS = 3'h1;
  localparam logic [2:0] OP_RD_ARRAY = 3'h3;
  localparam logic [2:0] OP_WR_ARRAY = 3'h2;
  localparam int OP_ADDR_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_PROT_LO_BIT = 2;
  localparam int ST_PROT_HI_BIT = 3;
  localparam logic [3:0] ST_ONES = 4'hF;
  localparam logic [1:0] PROT_DELIVERY = 2'h0;
  localparam logic [7:0] MEM_DELIVERY = 8'hFF;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int WCNT_W = 21;

  typedef enum logic [2:0] {
    REQ_NONE, REQ_SET_LATCH, REQ_CLR_LATCH, REQ_WR_STATUS, REQ_WR_ARRAY
  } sei_req_t;

  typedef enum logic [3:0] {
    LS_OPCODE, LS_RADDR, LS_WADDR, LS_RDATA, LS_WDATA, LS_STATUS, LS_WSDATA, LS_WAIT, LS_IGNORE
  } sei_link_st_t;

  // Array write lock check against the protect level
  function automatic logic sei_page_locked(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
    logic lock;
    lock = 1'b0;
    unique case (lvl)
      2'h0: lock = 1'b0;
      2'h1: lock = (a[8:7] == 2'h3);
      2'h2: lock = a[8];
      2'h3: lock = 1'b1;
    endcase
    return lock;
  endfunction
endpackage

/* File: rtl/sei_unit.sv */
`timescale 1ns/1ps
module sei_unit #(
  parameter int WRITE_CYCLES = sei_pkg::WRITE_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic wp_n_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic write_busy_o
);
  import sei_pkg::*;

  // Array and protect bits are non-volatile: no reset, delivery contents
  logic [7:0] mem_q [MEM_BYTES] = '{default: MEM_DELIVERY};
  logic [1:0] bp_reg = PROT_DELIVERY;
  logic [1:0] bp_next;

  // Link side, cleared while deselected
  sei_link_st_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [6:0] sh_reg, sh_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] tx_reg, tx_next;
  // Link side results, held after chip select rises
  sei_req_t req_reg, req_next;
  logic tgl_reg, tgl_next;
  logic [7:0] wsd_reg, wsd_next;
  logic [ADDR_W-1:0] wptr_reg, wptr_next;
  logic [PAGE_BYTES-1:0] mask_reg, mask_next;
  logic [7:0] page_q [PAGE_BYTES];
  logic pg_we;
  logic [3:0] stat_s1_reg, stat_s2_reg, stat_s3_reg, stat_q_reg, stat_q_next;
  logic miso_reg, miso_next, oe_reg, oe_next;
  logic [7:0] rx_byte, stat_byte;
  logic [ADDR_W-1:0] rd_start;

  // System side
  logic [2:0] cs_sy_reg, wp_sy_reg;
  logic cs_f_reg, cs_f_next, wp_f_reg, wp_f_next;
  logic cs_rise;
  logic wel_reg, wel_next, busy_reg, busy_next, last_tgl_reg, last_tgl_next;
  sei_req_t kind_reg, kind_next;
  logic [1:0] pbp_reg, pbp_next;
  logic [WCNT_W-1:0] wcnt_reg, wcnt_next;
  logic commit_arr;

  assign rx_byte = {sh_reg, mosi_i};
  assign stat_byte = {ST_ONES, stat_q_reg};
  assign rd_start = {addr_reg[ADDR_W-1], rx_byte};

  // Link next-state: opcode decode, address, data capture
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 3'h1;
    sh_next = rx_byte[6:0];
    addr_next = addr_reg;
    tx_next = tx_reg;
    req_next = REQ_NONE; // Any later edge cancels a pending request
    tgl_next = tgl_reg;
    wsd_next = wsd_reg;
    wptr_next = wptr_reg;
    mask_next = mask_reg;
    pg_we = 1'b0;
    stat_q_next = (stat_s2_reg == stat_s3_reg) ? stat_s3_reg : stat_q_reg;
    if (st_reg == LS_OPCODE && cnt_reg == 3'h0) begin
      tgl_next = ~tgl_reg; // Marks a new frame for the system side
    end
    if (st_reg == LS_WAIT) begin
      st_next = LS_IGNORE;
    end
    if (cnt_reg == 3'h7) begin
      unique case (st_reg)
        LS_OPCODE: begin
          st_next = LS_IGNORE;
          addr_next[ADDR_W-1] = rx_byte[OP_ADDR_BIT];
          if (rx_byte[7:4] == OP_UPPER) begin
            unique case (rx_byte[2:0])
              OP_SET_LATCH: begin
                st_next = LS_WAIT;
                req_next = REQ_SET_LATCH;
              end
              OP_CLR_LATCH: begin
                st_next = LS_WAIT;
                req_next = REQ_CLR_LATCH;
              end
              OP_RD_STATUS: begin
                st_next = LS_STATUS;
                tx_next = stat_byte;
              end
              OP_WR_STATUS: begin
                if (!stat_q_reg[ST_BUSY_BIT]) begin
                  st_next = LS_WSDATA;
                end
              end
              OP_RD_ARRAY: begin
                if (!stat_q_reg[ST_BUSY_BIT]) begin
                  st_next = LS_RADDR;
                end
              end
              OP_WR_ARRAY: begin
                if (!stat_q_reg[ST_BUSY_BIT]) begin
                  st_next = LS_WADDR;
                  mask_next = '0;
                end
              end
              default: ;
            endcase
          end
        end
        LS_RADDR: begin
          st_next = LS_RDATA;
          tx_next = mem_q[rd_start];
          addr_next = rd_start + 9'h001;
        end
        LS_RDATA: begin
          tx_next = mem_q[addr_reg];
          addr_next = addr_reg + 9'h001;     // Wraps to zero
        end
        LS_STATUS: tx_next = stat_byte;      // Live busy and latch
        LS_WADDR: begin
          st_next = LS_WDATA;
          wptr_next = rd_start;
        end
        LS_WDATA: begin
          pg_we = 1'b1;
          mask_next[wptr_reg[PAGE_W-1:0]] = 1'b1;
          wptr_next = {wptr_reg[ADDR_W-1:PAGE_W], wptr_reg[PAGE_W-1:0] + 4'h1};
          req_next = REQ_WR_ARRAY;           // Valid only on a byte boundary
        end
        LS_WSDATA: begin
          st_next = LS_WAIT;
          wsd_next = rx_byte;
          req_next = REQ_WR_STATUS;
        end
        LS_WAIT, LS_IGNORE: ;
      endcase
    end
  end

  // Per-frame state, reset by deselect
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      st_reg <= LS_OPCODE;
      cnt_reg <= 3'h0;
      sh_reg <= 7'h00;
      addr_reg <= '0;
      tx_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      tx_reg <= tx_next;
    end
  end

  // Frame results and status synchroniser on the serial clock
  always_ff @(posedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_reg <= REQ_NONE;
      tgl_reg <= 1'b0;
      wsd_reg <= 8'h00;
      wptr_reg <= '0;
      mask_reg <= '0;
      stat_s1_reg <= 4'h0;
      stat_s2_reg <= 4'h0;
      stat_s3_reg <= 4'h0;
      stat_q_reg <= 4'h0;
    end else begin
      req_reg <= req_next;
      tgl_reg <= tgl_next;
      wsd_reg <= wsd_next;
      wptr_reg <= wptr_next;
      mask_reg <= mask_next;
      stat_s1_reg <= {bp_reg, wel_reg, busy_reg};
      stat_s2_reg <= stat_s1_reg;
      stat_s3_reg <= stat_s2_reg;
      stat_q_reg <= stat_q_next;
    end
  end

  // Page buffer fill
  always_ff @(posedge sck_i) begin
    if (pg_we) begin
      page_q[wptr_reg[PAGE_W-1:0]] <= rx_byte;
    end
  end

  // Output bit, MSB first, updated on the falling edge
  always_comb begin
    miso_next = tx_reg[~cnt_reg];
    oe_next = (st_reg == LS_STATUS) || (st_reg == LS_RDATA);
  end

  // Output stops driving as soon as chip select rises
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      miso_reg <= miso_next;
      oe_reg <= oe_next;
    end
  end

  assign cs_rise = (cs_sy_reg[2] == cs_sy_reg[1]) && cs_sy_reg[2] && !cs_f_reg;

  // Acceptance checks and the self-timed write cycle
  always_comb begin
    cs_f_next = (cs_sy_reg[2] == cs_sy_reg[1]) ? cs_sy_reg[2] : cs_f_reg;
    wp_f_next = (wp_sy_reg[2] == wp_sy_reg[1]) ? wp_sy_reg[2] : wp_f_reg;
    wel_next = wel_reg;
    busy_next = busy_reg;
    kind_next = kind_reg;
    pbp_next = pbp_reg;
    wcnt_next = wcnt_reg;
    last_tgl_next = last_tgl_reg;
    bp_next = bp_reg;
    commit_arr = 1'b0;
    if (busy_reg) begin
      if (wcnt_reg == '0) begin
        busy_next = 1'b0;
        wel_next = 1'b0;
        if (kind_reg == REQ_WR_STATUS) begin
          bp_next = pbp_reg; // Protect bits change only now
        end else begin
          commit_arr = 1'b1;
        end
      end else begin
        wcnt_next = wcnt_reg - 21'h000001;
      end
    end
    if (cs_rise && tgl_reg != last_tgl_reg) begin
      last_tgl_next = tgl_reg;
      unique case (req_reg)
        REQ_SET_LATCH: wel_next = 1'b1;  // Set wins over a same-cycle completion clear, not over write-protect low
        REQ_CLR_LATCH: wel_next = 1'b0;
        REQ_WR_STATUS: begin
          if (wel_reg && !busy_reg && wp_f_reg) begin
            busy_next = 1'b1;
            kind_next = REQ_WR_STATUS;
            pbp_next = wsd_reg[ST_PROT_HI_BIT:ST_PROT_LO_BIT];
            wcnt_next = WCNT_W'(WRITE_CYCLES - 1);
          end
        end
        REQ_WR_ARRAY: begin
          if (wel_reg && !busy_reg && wp_f_reg && !sei_page_locked(wptr_reg, bp_reg)) begin
            busy_next = 1'b1;
            kind_next = REQ_WR_ARRAY;
            wcnt_next = WCNT_W'(WRITE_CYCLES - 1);
          end
        end
        REQ_NONE: ;
        default: ;
      endcase
    end
    if (!wp_f_reg) begin
      wel_next = 1'b0;
    end
  end

  // System-side registers; reset clears busy, latch and the write-cycle state
  always_ff @(posedge clk_sys_i) begin
    cs_sy_reg <= {cs_sy_reg[1:0], cs_n_i};
    wp_sy_reg <= {wp_sy_reg[1:0], wp_n_i};
    if (!nrst_i) begin
      cs_sy_reg <= 3'h7;
      wp_sy_reg <= 3'h0;
      cs_f_reg <= 1'b1;
      wp_f_reg <= 1'b0;
      wel_reg <= 1'b0;
      busy_reg <= 1'b0;
      kind_reg <= REQ_NONE;
      pbp_reg <= 2'h0;
      wcnt_reg <= '0;
      last_tgl_reg <= 1'b0;
    end else begin
      cs_f_reg <= cs_f_next;
      wp_f_reg <= wp_f_next;
      wel_reg <= wel_next;
      busy_reg <= busy_next;
      kind_reg <= kind_next;
      pbp_reg <= pbp_next;
      wcnt_reg <= wcnt_next;
      last_tgl_reg <= last_tgl_next;
    end
  end

  // Non-volatile state update at the end of a cycle
  always_ff @(posedge clk_sys_i) begin
    bp_reg <= bp_next;
    if (commit_arr) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_reg[i]) begin
          mem_q[{wptr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_q[i];
        end
      end
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe_o = oe_reg;
  assign write_busy_o = busy_reg;
endmodule

/* File: tb/sei_host.sv */
`timescale 1ns/1ps
module sei_host (
  input wire logic clk_sys_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  logic last_q;
  logic oe_seen;
  // Released line shows a changing pattern, never the held value
  wire logic line_w = miso_oe_o ? miso_o : ~last_q;
  // Chip select rises once at start so the frame logic is cleared, as after power-up
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = 1'b0;
    last_q = 1'b0;
    #1 cs_n_o = 1'b1;
  end
  always @(posedge sck_o) last_q <= line_w;
  // One bit: set while clock low, sampled at the rising edge
  task automatic bit1(input logic v, output logic q);
    mosi_o <= v;
    #6;
    q = line_w;
    if (miso_oe_o === 1'b1) oe_seen = 1'b1;
    sck_o <= 1'b1;
    #6 sck_o <= 1'b0;
  endtask
  // Byte, most significant bit first
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
  endtask
  task automatic sel();
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    oe_seen = 1'b0;
    #3;
  endtask
  // Deselect between the last rising edge and the next one
  task automatic desel();
    #3 cs_n_o <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule

/* File: tb/sei_unit_asserts.sv */
`timescale 1ns/1ps
module sei_chk #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic write_busy_o
);
  logic [31:0] blen_reg;
  logic [31:0] blen_next;
  // Length of the running busy period
  always_comb begin
    blen_next = write_busy_o ? blen_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys_i) begin
    blen_reg <= nrst_i ? blen_next : 32'h0;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Protect pin low long enough to reach the core
  sequence wp_held;
    !wp_n_i [*8];
  endsequence
  // Device driving data inside a frame
  sequence drive_on;
    miso_oe_o && !cs_n_i;
  endsequence
  a_oe_desel: assert property (cs_n_i |-> !miso_oe_o) else $error("drive while deselected");
  a_out_idle: assert property (cs_n_i |-> !miso_o) else $error("data out not idle");
  a_oe_in_frame: assert property ($rose(miso_oe_o) |-> !cs_n_i) else $error("drive outside frame");
  a_oe_holds: assert property (drive_on |=> miso_oe_o || cs_n_i) else $error("drive dropped");
  a_busy_desel: assert property ($rose(write_busy_o) |-> cs_n_i) else $error("write while selected");
  a_busy_min_run: assert property ($rose(write_busy_o) |-> write_busy_o [*8]) else $error("busy cut short");
  a_busy_len: assert property ($fell(write_busy_o) |-> blen_reg == WRITE_CYCLES) else $error("busy length");
  a_wp_no_write: assert property (wp_held |=> !$rose(write_busy_o)) else $error("write under wp");
endmodule

/* File: tb/sei_unit_tb.sv */
`timescale 1ns/1ps
module sei_unit_tb;
  import sei_pkg::*;
  logic clk_sys_i, nrst_i, wp_n_i, sck, cs_n, mosi, miso, miso_oe, busy;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] em [MEM_BYTES];
  logic [7:0] s;
  logic [7:0] bad [4] = '{8'h15, 8'h07, 8'h00, 8'hF3};
  sei_unit #(.WRITE_CYCLES(200)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n),
    .mosi_i(mosi), .wp_n_i(wp_n_i), .miso_o(miso), .miso_oe_o(miso_oe), .write_busy_o(busy));
  sei_host host (.clk_sys_i(clk_sys_i), .miso_o(miso), .miso_oe_o(miso_oe), .sck_o(sck), .cs_n_o(cs_n),
    .mosi_o(mosi));
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 300) begin
      chk(8'h01, 8'h00);
      stop_test();
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xb(op, s);
    host.desel();
  endtask
  task automatic fr2(input logic [7:0] a, input logic [7:0] b, input logic tail);
    logic q;
    host.sel();
    host.xb(a, s);
    host.xb(b, s);
    if (tail) host.bit1(1'b1, q);
    host.desel();
  endtask
  task automatic rd_st(input logic [7:0] op);
    fr2(op, 8'h00, 1'b0);
  endtask
  task automatic try_rd(input logic [7:0] op);
    host.sel();
    host.xb(op, s);
    host.xb(8'h00, s);
    host.xb(8'h00, s);
    host.desel();
  endtask
  task automatic wr_arr(input logic [8:0] a, input int n, input logic [7:0] v, input logic ok, input logic tail);
    logic q;
    cmd(8'h06);
    host.sel();
    host.xb({4'h0, a[8], OP_WR_ARRAY}, s);
    host.xb(a[7:0], s);
    for (int k = 0; k < n; k++) begin
      host.xb(v + 8'(k), s);
      if (ok) em[{a[8:4], a[3:0] + 4'(k)}] = v + 8'(k);
    end
    if (tail) host.bit1(1'b1, q);
    host.desel();
  endtask
  task automatic rd_arr(input logic [8:0] a, input int n);
    host.sel();
    host.xb({4'h0, a[8], OP_RD_ARRAY}, s);
    host.xb(a[7:0], s);
    for (int k = 0; k < n; k++) begin
      host.xb(8'h00, s);
      chk(s, em[a + 9'(k)]);
    end
    host.desel();
  endtask
  initial begin
    nrst_i = 1'b1;
    #1 nrst_i = 1'b0; // Clean falling edge for the serial-clock side reset
    wp_n_i = 1'b1;
    foreach (em[i]) em[i] = 8'hFF;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rd_st(8'h0D);
    chk(s, 8'hF0);
    cmd(8'h0E);
    rd_st(8'h05);
    chk(s, 8'hF2);
    cmd(8'h0C);
    rd_st(8'h05);
    chk(s, 8'hF0);
    $display("test latch done");
    wr_arr(9'h1F5, 18, 8'h10, 1'b1, 1'b0);
    chk(8'(busy), 8'h01);
    rd_st(8'h05);
    chk(8'(s[0]), 8'h01);
    try_rd({4'h0, 1'b1, OP_RD_ARRAY});
    chk(8'(host.oe_seen), 8'h00);
    wait_idle();
    rd_st(8'h05);
    chk(s, 8'hF0);
    rd_arr(9'h1F0, 17);
    $display("test page write done");
    cmd(8'h06);
    fr2(8'h01, 8'hFF, 1'b0);
    rd_st(8'h05);
    chk(s, 8'hF3);
    fr2(8'h01, 8'h00, 1'b0);
    wait_idle();
    rd_st(8'h05);
    chk(s, 8'hFC);
    wr_arr(9'h000, 1, 8'h33, 1'b0, 1'b0);
    chk(8'(busy), 8'h00);
    wp_n_i <= 1'b0;
    cmd(8'h06);
    rd_st(8'h05);
    chk(s, 8'hFC);
    fr2(8'h01, 8'h00, 1'b0);
    chk(8'(busy), 8'h00);
    wp_n_i <= 1'b1;
    cmd(8'h06);
    fr2(8'h01, 8'h00, 1'b1);
    chk(8'(busy), 8'h00);
    cmd(8'h06);
    fr2(8'h01, 8'h00, 1'b0);
    wait_idle();
    rd_st(8'h05);
    chk(s, 8'hF0);
    $display("test status write done");
    wr_arr(9'h010, 1, 8'h55, 1'b0, 1'b1);
    chk(8'(busy), 8'h00);
    rd_arr(9'h010, 1);
    cmd(8'h04);
    foreach (bad[i]) begin
      try_rd(bad[i]);
      chk(8'(host.oe_seen), 8'h00);
    end
    try_rd(8'h05);
    chk(8'(host.oe_seen), 8'h01);
    $display("test opcode done");
    stop_test();
  end
endmodule
bind sei_unit sei_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .cs_n_i(cs_n_i), .wp_n_i(wp_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .write_busy_o(write_busy_o));
